// ### core/ebap_top.sv
// address phase master of the external bus
`timescale 1ns/1ps
`include "ebap_consts.svh"
module ebap_top #(
  parameter int BURST_BEATS = `EBAP_BURST_BEATS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire ebap_pkg::ebap_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic err_o,
  input wire logic dphase_busy_i,
  input wire logic cs_ack_i,
  input wire logic bus_granted_in_n_i,
  input wire logic bus_occupied_n_i,
  output logic bus_occupied_n_o,
  output logic bus_occupied_oe_n_o,
  output ebap_pkg::ebap_attr_t attr_o,
  output logic transfer_start_n_o,
  output logic attr_oe_n_o,
  input wire logic addr_phase_ack_n_i,
  input wire logic burst_block_n_i,
  input wire logic beat_done_ack_n_i,
  input wire logic addr_redo_n_i,
  input wire logic xfer_fault_ack_n_i
);
  import ebap_pkg::*;

  if (BURST_BEATS < 2 || BURST_BEATS > 16) begin : g_chk
    $error("BURST_BEATS must lie in 2..16");
  end

  localparam logic [3:0] LAST_BEAT = 4'(BURST_BEATS - 1);
  localparam ebap_regs_t RST = '{state: S_IDLE, cur: '0, attr: '0, beats: 4'h0,
    seen_ta: 1'b0, own: 1'b0, ts_n: 1'b1, bb_n: 1'b1, bb_oe_n: 1'b1,
    attr_oe_n: 1'b1, ready: 1'b1, done: 1'b0, err: 1'b0};

  ebap_regs_t r_q;
  ebap_regs_t r_d;
  logic take;
  logic qual;
  logic ack;
  logic split;

  function automatic logic [3:0] lanes(ebap_req_t r);
    logic [3:0] b;
    b = 4'h0;
    if (r.port16) begin
      b[0] = (r.size != SZ_BYTE) || !r.addr[0];
      b[1] = (r.size != SZ_BYTE) || r.addr[0];
      b[2] = r.addr[1];
      b[3] = (r.size != SZ_WORD);
    end else begin
      unique case (r.size)
        SZ_BYTE: b[r.addr[1:0]] = 1'b1;
        SZ_HALF: b = r.addr[1] ? `EBAP_LANES_HI : `EBAP_LANES_LO;
        SZ_WORD: b = `EBAP_LANES_ALL;
        default: b = `EBAP_LANES_ALL;
      endcase
    end
    return b;
  endfunction

  always_comb begin
    r_d = r_q;
    r_d.ts_n = 1'b1;
    r_d.done = 1'b0;
    r_d.err = 1'b0;
    take = req_valid_i && r_q.ready;
    qual = !bus_granted_in_n_i && (r_q.own || bus_occupied_n_i);
    ack = !addr_phase_ack_n_i || (cs_ack_i && r_q.cur.cs_ack_en);
    split = r_q.cur.burst && ((r_q.beats != 4'h0) ||
      (!burst_block_n_i && !r_q.seen_ta));
    unique case (r_q.state)
      S_IDLE: begin
        r_d.bb_oe_n = 1'b1;
        r_d.attr_oe_n = 1'b1;
        if (take) begin
          r_d.cur = req_i;
          r_d.beats = 4'h0;
          r_d.state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (qual) begin
          r_d.state = S_ADDR;
          r_d.ts_n = 1'b0;
          r_d.bb_n = 1'b0;
          r_d.bb_oe_n = 1'b0;
          r_d.attr_oe_n = 1'b0;
          r_d.own = 1'b1;
          r_d.seen_ta = 1'b0;
          r_d.attr.addr = r_q.cur.addr[31:2];
          r_d.attr.write_read_n = !r_q.cur.write;
          r_d.attr.burst = r_q.cur.burst;
          r_d.attr.byte_lane_enable = lanes(r_q.cur);
        end
      end
      S_ADDR: begin
        if (!beat_done_ack_n_i) begin
          r_d.seen_ta = 1'b1;
        end
        // first cycle carries transfer start; acknowledges count from the next
        if (r_q.ts_n) begin
          if (!addr_redo_n_i) begin
            r_d.state = S_WAIT;
          end else if (!xfer_fault_ack_n_i) begin
            r_d.done = 1'b1;
            r_d.err = 1'b1;
            r_d.state = S_OWN;
          end else if (ack) begin
            if (split && r_q.beats != LAST_BEAT) begin
              r_d.beats = r_q.beats + 4'h1;
              r_d.cur.addr = r_q.cur.addr + `EBAP_WORD_STEP;
              r_d.state = S_WAIT;
            end else begin
              r_d.done = 1'b1;
              r_d.state = S_OWN;
            end
          end
        end
      end
      S_OWN: begin
        if (take) begin
          r_d.cur = req_i;
          r_d.beats = 4'h0;
          r_d.state = S_WAIT;
        end else if (!dphase_busy_i) begin
          r_d.state = S_IDLE;
          r_d.own = 1'b0;
          r_d.bb_n = 1'b1;
          r_d.attr_oe_n = bus_granted_in_n_i;
        end
      end
      default: r_d.state = S_IDLE;
    endcase
    r_d.ready = (r_d.state == S_IDLE) || (r_d.state == S_OWN);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r_q <= RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign req_ready_o = r_q.ready;
  assign done_o = r_q.done;
  assign err_o = r_q.err;
  assign bus_occupied_n_o = r_q.bb_n;
  assign bus_occupied_oe_n_o = r_q.bb_oe_n;
  assign attr_o = r_q.attr;
  assign transfer_start_n_o = r_q.ts_n;
  assign attr_oe_n_o = r_q.attr_oe_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence ack_inhibit_s;
    r_q.state == S_ADDR && r_q.ts_n && addr_redo_n_i && xfer_fault_ack_n_i && ack &&
      r_q.cur.burst && r_q.beats == 4'h0 && !burst_block_n_i && !r_q.seen_ta;
  endsequence
  sequence regrant_s;
    ##1 !bus_granted_in_n_i;
  endsequence
  sequence own_take_s;
    r_q.state == S_OWN && take;
  endsequence

  ts_one_clock_a: assert property (!r_q.ts_n |=> r_q.ts_n)
    else $error("transfer start held longer than one clock");
  ts_with_bus_a: assert property (!r_q.ts_n |-> !r_q.bb_n && !r_q.bb_oe_n && !r_q.attr_oe_n)
    else $error("transfer start without bus driven");
  grant_start_a: assert property (r_q.state == S_WAIT && qual |=> !r_q.ts_n)
    else $error("qualified grant did not start a cycle");
  attr_hold_a: assert property (r_q.state == S_ADDR && r_q.ts_n |-> $stable(r_q.attr))
    else $error("attributes changed during address phase");
  wr_level_a: assert property (!r_q.ts_n |-> r_q.attr.write_read_n == !r_q.cur.write)
    else $error("write_read_n level wrong");
  lanes16_a: assert property (!r_q.ts_n && r_q.cur.port16 |->
    r_q.attr.byte_lane_enable[2] == r_q.cur.addr[1] &&
    r_q.attr.byte_lane_enable[3] == (r_q.cur.size != SZ_WORD))
    else $error("16-bit port lane encoding wrong");
  burst_flag_a: assert property (!r_q.ts_n |-> r_q.attr.burst == r_q.cur.burst)
    else $error("burst indicator wrong");
  split_step_a: assert property (ack_inhibit_s ##0 regrant_s |=> !r_q.ts_n &&
    r_q.attr.addr == 30'($past(r_q.attr.addr, 2) + 30'h1))
    else $error("inhibited burst not split with next address");
  cs_ack_end_a: assert property (r_q.state == S_ADDR && r_q.ts_n && addr_redo_n_i &&
    xfer_fault_ack_n_i && cs_ack_i && r_q.cur.cs_ack_en |=> r_q.state != S_ADDR)
    else $error("internal acknowledge did not end address phase");
  float_idle_a: assert property (r_q.state == S_IDLE && $past(r_q.state) == S_IDLE |->
    r_q.attr_oe_n)
    else $error("attributes driven while bus idle");
  lanes32_a: assert property (!r_q.ts_n && !r_q.cur.port16 && r_q.cur.size == SZ_WORD |->
    r_q.attr.byte_lane_enable == 4'hf)
    else $error("32-bit port word lanes wrong");
  lanes16_lo_a: assert property (!r_q.ts_n && r_q.cur.port16 && r_q.cur.size != SZ_BYTE |->
    r_q.attr.byte_lane_enable[1:0] == 2'h3)
    else $error("16-bit port low lanes wrong");
  addr_word_a: assert property (!r_q.ts_n |-> r_q.attr.addr == r_q.cur.addr[31:2])
    else $error("word address wrong");
  attr_change_a: assert property (!$stable(r_q.attr) |-> !r_q.ts_n)
    else $error("attributes changed outside address phase start");
  release_float_a: assert property (r_q.state == S_OWN && !take && !dphase_busy_i &&
    bus_granted_in_n_i |=> r_q.bb_n && r_q.attr_oe_n)
    else $error("attributes still driven after release without grant");
  parked_drive_a: assert property (r_q.state == S_OWN && !take && !dphase_busy_i &&
    !bus_granted_in_n_i |=> r_q.bb_n && !r_q.attr_oe_n)
    else $error("attributes floated while grant held");
  pipe_start_a: assert property (own_take_s ##0 regrant_s |=> !r_q.ts_n)
    else $error("pipelined request did not start next address phase");
  redo_wait_a: assert property (r_q.state == S_ADDR && r_q.ts_n && !addr_redo_n_i |=>
    r_q.state == S_WAIT && !r_q.done)
    else $error("redo did not return to grant wait");
  fault_end_a: assert property (r_q.state == S_ADDR && r_q.ts_n && addr_redo_n_i &&
    !xfer_fault_ack_n_i |=> r_q.done && r_q.err)
    else $error("fault did not end the request");
endmodule

// ### core/ebap_consts.svh
// constants of the external bus address phase block
// What this block does
// - drive a 30-bit word address; lowest bits replaced by byte lane enables
// - on 16-bit ports the third byte lane enable carries address bit 1
// - drive address one clock after qualified grant, with bus_occupied and transfer_start_n
// - float address and attributes when releasing bus_occupied; a held grant keeps them driven one clock longer
// - write_read_n high for reads, low for writes
// - update attributes at address phase start, hold until next address phase
// - burst indicator marks bursts, stays asserted on decomposed single beats
// - on 32-bit ports the four enables select lanes 0-7 up to 24-31
// - on 16-bit ports enables 0 and 1 select lanes; bit 3 is 0 for words
// - transfer_start_n low for exactly one clock at cycle start
// - early address acknowledge lets the next address phase start during data
// - keep address and attributes driven while unacknowledged and bus_occupied held
// - internal chip-select acknowledge is ORed in and never shown on the pin
// - burst_block_n splits a burst into single transfers with incrementing address
// - sample burst_block_n with the acknowledge; honour only before first beat_done_ack
// - grant qualified only with bus_granted_in and bus_occupied released by others
// - address phase runs from transfer_start_n until ack, redo or fault
`ifndef EBAP_CONSTS_SVH
`define EBAP_CONSTS_SVH
`define EBAP_BURST_BEATS 4
`define EBAP_WORD_STEP 32'h0000_0004
`define EBAP_LANES_ALL 4'hf
`define EBAP_LANES_HI 4'hc
`define EBAP_LANES_LO 4'h3
`endif

// ### core/ebap_pkg.sv
// types of the external bus address phase block
package ebap_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} ebap_size_t;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ADDR, S_OWN} ebap_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic burst;
    ebap_size_t size;
    logic port16;
    logic cs_ack_en;
  } ebap_req_t;
  typedef struct packed {
    logic [29:0] addr;
    logic write_read_n;
    logic burst;
    logic [3:0] byte_lane_enable;
  } ebap_attr_t;
  typedef struct packed {
    ebap_state_t state;
    ebap_req_t cur;
    ebap_attr_t attr;
    logic [3:0] beats;
    logic seen_ta;
    logic own;
    logic ts_n;
    logic bb_n;
    logic bb_oe_n;
    logic attr_oe_n;
    logic ready;
    logic done;
    logic err;
  } ebap_regs_t;
endpackage

// ### tb/ebap_slave.sv
// bus slave model answering the address phase
`timescale 1ns/1ps
module ebap_slave (
  input wire logic clk_i,
  input wire logic ts_n_i,
  input wire logic [3:0] delay_i,
  input wire logic inhibit_i,
  input wire logic cs_mode_i,
  output logic ack_n_o,
  output logic cs_ack_o,
  output logic bi_n_o,
  output logic ta_n_o
);
  logic [3:0] cnt_q = 4'h0;
  logic busy_q = 1'b0;
  logic hit;
  // write_read_n is never looked at by this slave
  assign hit = busy_q && cnt_q == 4'h0;
  always @(posedge clk_i) begin
    if (!ts_n_i) begin
      busy_q <= 1'b1;
      cnt_q <= delay_i;
    end else if (hit) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign ack_n_o = ~(hit & ~cs_mode_i);
  assign cs_ack_o = hit & cs_mode_i;
  assign bi_n_o = hit ? ~inhibit_i : 1'b1;
  assign ta_n_o = ~hit;
endmodule

// ### tb/tb.sv
// self-checking bench of the address phase master
`timescale 1ns/1ps
module tb;
  import ebap_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic valid = 1'b0;
  logic gnt_n = 1'b0;
  ebap_req_t req = '0;
  logic [3:0] dly = 4'h0;
  logic inh = 1'b0;
  logic csm = 1'b0;
  logic dbusy = 1'b0;
  logic other_bb_n = 1'b1;
  logic redo_n = 1'b1;
  logic tea_n = 1'b1;
  logic ready, done, err, bb_n, bb_oe_n, ts_n, oe_n, ack_n, cs_ack, bi_n, ta_n;
  logic prev_ts = 1'b1;
  logic in_ph = 1'b0;
  ebap_attr_t attr, ph, first_attr;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int ts_cnt = 0;
  always #25 clk = ~clk;
  ebap_top #(.BURST_BEATS(4)) DUT (.clk_i(clk), .reset_i(reset), .req_valid_i(valid),
    .req_i(req), .req_ready_o(ready), .done_o(done), .err_o(err), .dphase_busy_i(dbusy),
    .cs_ack_i(cs_ack), .bus_granted_in_n_i(gnt_n),
    .bus_occupied_n_i((bb_oe_n | bb_n) & other_bb_n),
    .bus_occupied_n_o(bb_n), .bus_occupied_oe_n_o(bb_oe_n), .attr_o(attr),
    .transfer_start_n_o(ts_n), .attr_oe_n_o(oe_n), .addr_phase_ack_n_i(ack_n),
    .burst_block_n_i(bi_n), .beat_done_ack_n_i(ta_n), .addr_redo_n_i(redo_n),
    .xfer_fault_ack_n_i(tea_n));
  ebap_slave slave (.clk_i(clk), .ts_n_i(ts_n), .delay_i(dly), .inhibit_i(inh),
    .cs_mode_i(csm), .ack_n_o(ack_n), .cs_ack_o(cs_ack), .bi_n_o(bi_n), .ta_n_o(ta_n));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      bad_count++;
      stop_test();
    end else begin
      if (in_ph) check(attr, ph);
      if (ack_n === 1'b0 || cs_ack === 1'b1 || err === 1'b1) in_ph = 1'b0;
      if (ts_n === 1'b0) begin
        check(prev_ts, 1);
        check({bb_n, oe_n}, 0);
        ts_cnt++;
        ph = attr;
        in_ph = 1'b1;
        if (ts_cnt == 1) first_attr = attr;
      end
      prev_ts = ts_n;
    end
  end
  task automatic run(input ebap_req_t r, input int n_ts, input logic [29:0] a0);
    int k;
    ts_cnt = 0;
    @(negedge clk);
    req = r;
    valid = 1'b1;
    for (k = 0; k < 20 && ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
    check(ready, 0);
    for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
    check(done, 1);
    check(err, 0);
    check(ts_cnt, n_ts);
    check(first_attr.addr, a0);
  endtask
  task automatic s_read();
    dly = 4'h3;
    run('{32'h0000_1230, 1'b0, 1'b0, SZ_WORD, 1'b0, 1'b0}, 1, 30'h0000_048c);
    check({first_attr.write_read_n, first_attr.burst}, 2'b10);
    check(first_attr.byte_lane_enable, 4'hf);
  endtask
  task automatic s_port16();
    dly = 4'h0;
    run('{32'h0000_0102, 1'b1, 1'b0, SZ_BYTE, 1'b1, 1'b0}, 1, 30'h0000_0040);
    check(first_attr.write_read_n, 0);
    check(first_attr.byte_lane_enable[3:2], 2'b11);
    run('{32'h0000_0200, 1'b0, 1'b0, SZ_WORD, 1'b1, 1'b0}, 1, 30'h0000_0080);
    check(first_attr.byte_lane_enable[3:2], 2'b00);
  endtask
  task automatic s_burst();
    inh = 1'b1;
    run('{32'h0000_2000, 1'b0, 1'b1, SZ_WORD, 1'b0, 1'b0}, 4, 30'h0000_0800);
    check({ph.addr, ph.burst}, {30'h0000_0803, 1'b1});
    inh = 1'b0;
  endtask
  task automatic s_cs();
    csm = 1'b1;
    dly = 4'h1;
    run('{32'h0000_3000, 1'b1, 1'b0, SZ_WORD, 1'b0, 1'b1}, 1, 30'h0000_0c00);
    csm = 1'b0;
    check(ack_n, 1);
  endtask
  task automatic s_release();
    dbusy = 1'b1;
    run('{32'h0000_4000, 1'b0, 1'b0, SZ_WORD, 1'b0, 1'b0}, 1, 30'h0000_1000);
    run('{32'h0000_4004, 1'b1, 1'b0, SZ_WORD, 1'b0, 1'b0}, 1, 30'h0000_1001);
    check({bb_n, bb_oe_n}, 2'b00);
    dbusy = 1'b0;
    @(negedge clk);
    check({bb_n, oe_n, bb_oe_n}, 3'b100);
    @(negedge clk);
    check({bb_n, oe_n, bb_oe_n}, 3'b111);
    dbusy = 1'b1;
    run('{32'h0000_4008, 1'b0, 1'b0, SZ_HALF, 1'b0, 1'b0}, 1, 30'h0000_1002);
    check(first_attr.byte_lane_enable, 4'h3);
    gnt_n = 1'b1;
    dbusy = 1'b0;
    @(negedge clk);
    check({bb_n, oe_n, bb_oe_n}, 3'b110);
    repeat (4) @(negedge clk);
    check({oe_n, bb_oe_n}, 2'b11);
  endtask
  task automatic s_other();
    int k;
    ts_cnt = 0;
    gnt_n = 1'b0;
    other_bb_n = 1'b0;
    @(negedge clk);
    req = '{32'h0000_5000, 1'b0, 1'b0, SZ_WORD, 1'b0, 1'b0};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    repeat (4) @(negedge clk);
    check(ts_cnt, 0);
    other_bb_n = 1'b1;
    for (k = 0; k < 50 && done !== 1'b1; k++) @(negedge clk);
    check(done, 1);
    check(first_attr.addr, 30'h0000_1400);
  endtask
  task automatic s_redo();
    int k;
    dly = 4'hf;
    ts_cnt = 0;
    @(negedge clk);
    req = '{32'h0000_6000, 1'b1, 1'b0, SZ_WORD, 1'b0, 1'b0};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    for (k = 0; k < 20 && ts_n !== 1'b0; k++) @(negedge clk);
    @(negedge clk);
    redo_n = 1'b0;
    @(negedge clk);
    redo_n = 1'b1;
    for (k = 0; k < 20 && ts_n !== 1'b0; k++) @(negedge clk);
    @(negedge clk);
    check(ts_cnt, 2);
    check(attr.addr, 30'h0000_1800);
    tea_n = 1'b0;
    @(negedge clk);
    tea_n = 1'b1;
    check({done, err}, 2'b11);
    @(negedge clk);
    check({done, err}, 2'b00);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    s_read();
    s_port16();
    s_burst();
    s_cs();
    s_release();
    s_other();
    s_redo();
    stop_test();
  end
endmodule
